// *** src/nibble_swap_xor_direction_ops.sv ***
`timescale 1ns/100ps
// Contract
// [RULE1] Opcode 00 1110 swaps the nibbles of register f; flags unchanged.
// [RULE2] Swap with d of 0 writes the accumulator, with d of 1 register f.
// [RULE3] 00 0000 0110 0fff, f of 5 to 7, loads the accumulator into dir f.
// [RULE4] Direction registers are also reachable by normal data addressing.
// [RULE5] Opcode 11 1010 XORs the literal into the accumulator, sets zero.
// [RULE6] The literal XOR result always goes into the accumulator.
// [RULE7] Each of the three instructions is one word and one cycle.
module nibble_swap_xor_direction_ops
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Instruction
	input wire logic insn_valid_i,
	input wire logic [insn_pkg::INSN_W-1:0] insn_i,
	// Register file read data for the addressed file register
	input wire logic [insn_pkg::WORD_W-1:0] file_rdata_i,
	// Normal data path writes to and reads of file registers
	input wire logic data_wr_i,
	input wire logic [insn_pkg::FADDR_W-1:0] data_waddr_i,
	input wire logic [insn_pkg::WORD_W-1:0] data_wdata_i,
	input wire logic [insn_pkg::FADDR_W-1:0] data_raddr_i,
	// Results
	output logic [insn_pkg::FADDR_W-1:0] file_addr_o,
	output logic file_wr_o,
	output logic [insn_pkg::WORD_W-1:0] file_wdata_o,
	output logic [insn_pkg::WORD_W-1:0] accum_o,
	output logic zero_flag_o,
	output logic zero_wr_o,
	output logic done_o,
	output logic [insn_pkg::WORD_W-1:0] dir_rdata_o,
	output logic [insn_pkg::WORD_W*insn_pkg::DIR_CNT-1:0] dir_o
);
	typedef enum logic [1:0]
	{
		OPK_NONE = 2'b00,
		OPK_SWAP = 2'b01,
		OPK_DIRLD = 2'b10,
		OPK_XORL = 2'b11
	} op_kind_t;

	op_kind_t kind;
	logic dst_file;
	logic [insn_pkg::WORD_W-1:0] swapped;
	logic [insn_pkg::WORD_W-1:0] xored;
	logic [2:0] dsel;
	logic [insn_pkg::WORD_W-1:0] dir_val [insn_pkg::DIR_CNT];
	logic [insn_pkg::DIR_CNT-1:0] dir_we;
	logic [insn_pkg::WORD_W-1:0] dir_wd [insn_pkg::DIR_CNT];

	logic [insn_pkg::FADDR_W-1:0] file_addr_r, file_addr_nxt;
	logic file_wr_r, file_wr_nxt;
	logic [insn_pkg::WORD_W-1:0] file_wdata_r, file_wdata_nxt;
	logic [insn_pkg::WORD_W-1:0] accum_r, accum_nxt;
	logic zero_r, zero_nxt;
	logic zero_wr_r, zero_wr_nxt;
	logic done_r, done_nxt;
	logic [insn_pkg::WORD_W-1:0] dir_rdata_r, dir_rdata_nxt;

	assign dsel = insn_i[insn_pkg::SEL_W-1:0];

	always_comb
	begin
		kind = OPK_NONE;
		if (insn_valid_i)
		begin
			if (insn_i[insn_pkg::INSN_W-1:insn_pkg::SWAP_OPC_LSB]
				== insn_pkg::OP_SWAP) // [RULE1]
				kind = OPK_SWAP;
			else if (insn_i[insn_pkg::INSN_W-1:insn_pkg::DIRLD_OPC_LSB]
				== insn_pkg::OP_DIRLD
				&& dsel >= insn_pkg::DIR_SEL_LO
				&& dsel <= insn_pkg::DIR_SEL_HI) // [RULE3]
				kind = OPK_DIRLD;
			else if (insn_i[insn_pkg::INSN_W-1:insn_pkg::LIT_CLASS_LSB]
				== insn_pkg::OP_LIT_CLASS
				&& insn_i[insn_pkg::LIT_CLASS_LSB-1:insn_pkg::XORL_OPC_LSB]
				== insn_pkg::OP_XORL) // [RULE5]
				kind = OPK_XORL;
		end
	end

	assign dst_file = insn_i[insn_pkg::DST_BIT];
	assign swapped = {file_rdata_i[insn_pkg::NIB_W-1:0],
		file_rdata_i[insn_pkg::WORD_W-1:insn_pkg::NIB_W]}; // [RULE1]
	assign xored = accum_r ^ insn_i[insn_pkg::WORD_W-1:0]; // [RULE5]

	// Direction registers: legacy load, direct data writes, swap write-back
	genvar gi;
	generate
		for (gi = 0; gi < insn_pkg::DIR_CNT; gi++)
		begin : g_dir
			localparam logic [insn_pkg::FADDR_W-1:0] FA =
				insn_pkg::DIR_FADDR_BASE + insn_pkg::FADDR_W'(gi);
			always_comb
			begin
				dir_we[gi] = 1'b0;
				dir_wd[gi] = accum_r;
				if (kind == OPK_DIRLD && dsel == 3'(FA)) // [RULE3]
					dir_we[gi] = 1'b1;
				else if (kind == OPK_SWAP && dst_file
					&& insn_i[insn_pkg::FADDR_W-1:0] == FA)
				begin
					dir_we[gi] = 1'b1;
					dir_wd[gi] = swapped;
				end
				else if (data_wr_i && data_waddr_i == FA) // [RULE4]
				begin
					dir_we[gi] = 1'b1;
					dir_wd[gi] = data_wdata_i;
				end
			end
			dir_reg u_dir
			(
				.core_clk_i(core_clk_i),
				.sys_rst_i(sys_rst_i),
				.wr_en_i(dir_we[gi]),
				.wr_data_i(dir_wd[gi]),
				.value_o(dir_val[gi])
			);
			assign dir_o[gi*insn_pkg::WORD_W +: insn_pkg::WORD_W] = dir_val[gi];
		end
	endgenerate

	always_comb
	begin
		file_addr_nxt = insn_i[insn_pkg::FADDR_W-1:0];
		file_wr_nxt = 1'b0;
		file_wdata_nxt = swapped;
		accum_nxt = accum_r;
		zero_nxt = zero_r;
		zero_wr_nxt = 1'b0;
		done_nxt = kind != OPK_NONE; // [RULE7]
		dir_rdata_nxt = insn_pkg::ZERO_BYTE;
		if (data_raddr_i >= insn_pkg::DIR_FADDR_BASE
			&& data_raddr_i <= insn_pkg::DIR_FADDR_TOP) // [RULE4]
			dir_rdata_nxt = dir_val[2'(data_raddr_i
				- insn_pkg::DIR_FADDR_BASE)];
		case (kind)
			OPK_SWAP:
			begin
				if (dst_file) // [RULE2]
					file_wr_nxt = 1'b1;
				else
					accum_nxt = swapped;
			end
			OPK_XORL:
			begin
				accum_nxt = xored; // [RULE6]
				zero_nxt = xored == insn_pkg::ZERO_BYTE; // [RULE5]
				zero_wr_nxt = 1'b1;
			end
			default:
			begin
			end
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			file_addr_r <= '0;
			file_wr_r <= 1'b0;
			file_wdata_r <= insn_pkg::ZERO_BYTE;
			accum_r <= insn_pkg::ZERO_BYTE;
			zero_r <= 1'b0;
			zero_wr_r <= 1'b0;
			done_r <= 1'b0;
			dir_rdata_r <= insn_pkg::ZERO_BYTE;
		end
		else
		begin
			file_addr_r <= file_addr_nxt;
			file_wr_r <= file_wr_nxt;
			file_wdata_r <= file_wdata_nxt;
			accum_r <= accum_nxt;
			zero_r <= zero_nxt;
			zero_wr_r <= zero_wr_nxt;
			done_r <= done_nxt;
			dir_rdata_r <= dir_rdata_nxt;
		end
	end

	assign file_addr_o = file_addr_r;
	assign file_wr_o = file_wr_r;
	assign file_wdata_o = file_wdata_r;
	assign accum_o = accum_r;
	assign zero_flag_o = zero_r;
	assign zero_wr_o = zero_wr_r;
	assign done_o = done_r;
	assign dir_rdata_o = dir_rdata_r;

	sequence s_swap_acc;
		kind == OPK_SWAP && !dst_file;
	endsequence
	sequence s_xorl;
		kind == OPK_XORL;
	endsequence

	a_swap_nibbles: assert property (@(posedge core_clk_i) // [RULE1]
		disable iff (sys_rst_i) s_swap_acc |=> accum_o ==
		insn_pkg::WORD_W'({2{$past(file_rdata_i)}} >> insn_pkg::NIB_W))
		else $error("swap result wrong");
	a_swap_flags: assert property (@(posedge core_clk_i) // [RULE1]
		disable iff (sys_rst_i) kind == OPK_SWAP |=> !zero_wr_o
		&& $stable(zero_flag_o))
		else $error("swap touched flags");
	a_swap_dest: assert property (@(posedge core_clk_i) // [RULE2]
		disable iff (sys_rst_i) kind == OPK_SWAP && dst_file |=>
		file_wr_o && $stable(accum_o))
		else $error("swap destination wrong");
	a_dirld_copy: assert property (@(posedge core_clk_i) // [RULE3]
		disable iff (sys_rst_i) kind == OPK_DIRLD
		&& dsel == insn_pkg::DIR_SEL_HI |=>
		dir_o[(insn_pkg::DIR_CNT-1)*insn_pkg::WORD_W +: insn_pkg::WORD_W]
		== $past(accum_o) && !zero_wr_o)
		else $error("direction load wrong");
	a_dir_data_wr: assert property (@(posedge core_clk_i) // [RULE4]
		disable iff (sys_rst_i) insn_valid_i == 1'b0 && data_wr_i
		&& data_waddr_i == insn_pkg::DIR_FADDR_TOP |=>
		dir_o[(insn_pkg::DIR_CNT-1)*insn_pkg::WORD_W +: insn_pkg::WORD_W]
		== $past(data_wdata_i))
		else $error("direct direction write lost");
	a_xor_zero: assert property (@(posedge core_clk_i) // [RULE5]
		disable iff (sys_rst_i) s_xorl |=> zero_wr_o &&
		zero_flag_o == (accum_o == insn_pkg::ZERO_BYTE))
		else $error("zero flag wrong");
	a_xor_accum: assert property (@(posedge core_clk_i) // [RULE6]
		disable iff (sys_rst_i) s_xorl |=> accum_o ==
		($past(accum_o) ^ $past(insn_i[insn_pkg::WORD_W-1:0]))
		&& !file_wr_o)
		else $error("xor result wrong");
	a_one_cycle: assert property (@(posedge core_clk_i) // [RULE7]
		disable iff (sys_rst_i) kind != OPK_NONE |=> done_o)
		else $error("instruction not done in one cycle");
endmodule // nibble_swap_xor_direction_ops

// *** src/insn_pkg.sv ***
package insn_pkg;
	localparam int WORD_W = 8;
	localparam int INSN_W = 14;
	localparam int FADDR_W = 7;
	localparam int NIB_W = 4;
	// Instruction field positions
	localparam int SWAP_OPC_LSB = 8;
	localparam int DIRLD_OPC_LSB = 3;
	localparam int LIT_CLASS_LSB = 12;
	localparam int XORL_OPC_LSB = 8;
	localparam int DST_BIT = 7;
	localparam int SEL_W = 3;
	// Opcode fields
	localparam logic [5:0] OP_SWAP = 6'h0E;
	localparam logic [3:0] OP_XORL = 4'hA;
	localparam logic [1:0] OP_LIT_CLASS = 2'h3;
	localparam logic [10:0] OP_DIRLD = 11'h00C;
	// Direction register file addresses and legacy selectors
	localparam logic [2:0] DIR_SEL_LO = 3'h5;
	localparam logic [2:0] DIR_SEL_HI = 3'h7;
	localparam logic [FADDR_W-1:0] DIR_FADDR_BASE = 7'h05;
	localparam logic [FADDR_W-1:0] DIR_FADDR_TOP = 7'h07;
	localparam int DIR_BANK_OFS = 128;
	localparam int DIR_CNT = 3;
	localparam logic [WORD_W-1:0] DIR_RESET = 8'hFF;
	localparam logic [WORD_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [1:0] DIR_IDX_LO = 2'h0;
endpackage

// *** src/dir_reg.sv ***
`timescale 1ns/100ps
module dir_reg
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [insn_pkg::WORD_W-1:0] wr_data_i,
	// Content
	output logic [insn_pkg::WORD_W-1:0] value_o
);
	logic [insn_pkg::WORD_W-1:0] value_r;
	logic [insn_pkg::WORD_W-1:0] value_nxt;

	always_comb
	begin
		value_nxt = wr_en_i ? wr_data_i : value_r;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			value_r <= insn_pkg::DIR_RESET;
		else
			value_r <= value_nxt;
	end

	assign value_o = value_r;
endmodule // dir_reg

// *** sim/nibble_swap_xor_direction_ops_tb.sv ***
`timescale 1ns/100ps
module nibble_swap_xor_direction_ops_tb;
	logic core_clk_i;
	logic sys_rst_i;
	logic insn_valid_i;
	logic [13:0] insn_i;
	logic [7:0] file_rdata_i;
	logic data_wr_i;
	logic [6:0] data_waddr_i;
	logic [7:0] data_wdata_i;
	logic [6:0] data_raddr_i;
	logic [6:0] file_addr_o;
	logic file_wr_o;
	logic [7:0] file_wdata_o;
	logic [7:0] accum_o;
	logic zero_flag_o;
	logic zero_wr_o;
	logic done_o;
	logic [7:0] dir_rdata_o;
	logic [23:0] dir_o;
	logic [7:0] acc;
	logic [23:0] dexp;
	int bad_count;
	int n_compared;
	int cycles;

	nibble_swap_xor_direction_ops DUT
	(
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.insn_valid_i(insn_valid_i),
		.insn_i(insn_i),
		.file_rdata_i(file_rdata_i),
		.data_wr_i(data_wr_i),
		.data_waddr_i(data_waddr_i),
		.data_wdata_i(data_wdata_i),
		.data_raddr_i(data_raddr_i),
		.file_addr_o(file_addr_o),
		.file_wr_o(file_wr_o),
		.file_wdata_o(file_wdata_o),
		.accum_o(accum_o),
		.zero_flag_o(zero_flag_o),
		.zero_wr_o(zero_wr_o),
		.done_o(done_o),
		.dir_rdata_o(dir_rdata_o),
		.dir_o(dir_o)
	);

	task automatic chk(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Valid stays high so that calls run back to back
	task automatic issue(input logic [13:0] w, input logic [7:0] rd);
		insn_i = w;
		file_rdata_i = rd;
		insn_valid_i = 1'b1;
		@(posedge core_clk_i);
		#1;
	endtask

	task automatic xl(input logic [7:0] k);
		issue({6'h3A, k}, 8'h00);
		acc = acc ^ k;
		chk("accum", accum_o, acc);
		chk("zero", zero_flag_o, acc == 8'h00);
		chk("zero_wr", zero_wr_o, 1'b1);
		chk("done", done_o, 1'b1);
	endtask

	task automatic t_xor;
		xl(8'hB5);
		xl(8'hAF);
		xl(8'h1A);
	endtask

	task automatic t_swap;
		issue(14'h0E05, 8'hA5);
		acc = 8'h5A;
		chk("accum", accum_o, acc);
		chk("zero kept", zero_flag_o, 1'b1);
		chk("zero_wr", zero_wr_o, 1'b0);
		chk("file_wr", file_wr_o, 1'b0);
		issue(14'h0EA5, 8'h3C);
		chk("file_wr", file_wr_o, 1'b1);
		chk("file_wdata", file_wdata_o, 8'hC3);
		chk("file_addr", file_addr_o, 7'h25);
		chk("accum kept", accum_o, acc);
		chk("done", done_o, 1'b1);
	endtask

	task automatic t_dir;
		for (int f = 5; f <= 7; f++)
		begin
			xl(8'(f));
			issue(14'h0060 | 14'(f), 8'h00);
			dexp[(f-5)*8 +: 8] = acc;
			chk("dir", dir_o, dexp);
			chk("zero_wr", zero_wr_o, 1'b0);
			chk("done", done_o, 1'b1);
		end
		issue(14'h0064, 8'h00);
		chk("refused done", done_o, 1'b0);
		chk("refused dir", dir_o, dexp);
		issue(14'h3F00, 8'h00);
		chk("other done", done_o, 1'b0);
		chk("other accum", accum_o, acc);
	endtask

	task automatic t_data;
		insn_valid_i = 1'b0;
		data_waddr_i = 7'h06;
		data_wdata_i = 8'h3C;
		data_wr_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		data_waddr_i = 7'h07;
		data_wdata_i = 8'h96;
		@(posedge core_clk_i);
		#1;
		data_wr_i = 1'b0;
		data_raddr_i = 7'h06;
		dexp[23:8] = 16'h963C;
		chk("dir by data", dir_o, dexp);
		@(posedge core_clk_i);
		#1;
		data_raddr_i = 7'h07;
		chk("dir read", dir_rdata_o, 8'h3C);
		@(posedge core_clk_i);
		#1;
		data_raddr_i = 7'h08;
		chk("dir read top", dir_rdata_o, 8'h96);
		@(posedge core_clk_i);
		#1;
		chk("other read", dir_rdata_o, 8'h00);
		issue(14'h0E86, dexp[15:8]);
		dexp[15:8] = 8'hC3;
		chk("dir by swap", dir_o, dexp);
		chk("swap file_wr", file_wr_o, 1'b1);
		chk("swap file_addr", file_addr_o, 7'h06);
	endtask

	task automatic finish_test;
		$display("Compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// Cuts a hang short
	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			bad_count++;
			finish_test();
		end
	end

	initial
	begin
		sys_rst_i = 1'b1;
		insn_valid_i = 1'b0;
		insn_i = 14'h0000;
		file_rdata_i = 8'h00;
		data_wr_i = 1'b0;
		data_waddr_i = 7'h00;
		data_wdata_i = 8'h00;
		data_raddr_i = 7'h00;
		acc = 8'h00;
		dexp = 24'hFFFFFF;
		repeat (12) @(posedge core_clk_i);
		#1;
		sys_rst_i = 1'b0;
		chk("reset dir", dir_o, dexp);
		chk("reset accum", accum_o, acc);
		t_xor();
		t_swap();
		t_dir();
		t_data();
		finish_test();
	end
endmodule // nibble_swap_xor_direction_ops_tb
